// ### bench/dtc_decoder_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_decoder_sva
    import dtc_pkg::*;
#(
    parameter int unsigned N_TERM = 8
) (
    input wire logic              core_clk,
    input wire logic              rst_n,
    input wire logic [N_TERM-1:0] term_pin,
    input wire logic              motor_running,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire dtc_cmd_type       cmd,
    input wire logic              bias_en,
    input wire logic [15:0]       bias_level,
    input wire logic              freq_restore,
    input wire logic [N_TERM-1:0] user_logic_terms
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Motor start as seen on the core's run level
    sequence s_run_rise;
        !motor_running ##1 motor_running;
    endsequence
    a_read_data_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_bias_off_zero: assert property (!bias_en |-> bias_level == 16'h0)
        else $error("bias level while bias off");
    a_select_frozen: assert property ($past(motor_running) |-> $stable(bias_en))
        else $error("bias select moved while driven");
    a_run_exclusive: assert property (!(cmd.run_forward && cmd.run_backward))
        else $error("both directions commanded");
    a_run_no_stop: assert property (
        (cmd.run_forward || cmd.run_backward) |-> !cmd.decel_stop)
        else $error("stop while running");
    a_alarm_cause: assert property (
        $rose(cmd.alarm_stop) |-> $past(motor_running, 2))
        else $error("alarm without running motor");
    a_restore_cause: assert property (freq_restore |->
        $past(motor_running) && !$past(motor_running, 2))
        else $error("restore not at start");
    a_restore_once: assert property (
        s_run_rise ##1 freq_restore |=> !freq_restore)
        else $error("restore pulse too long");
    a_deb_stable: assert property ($rose(user_logic_terms[0]) |->
        $past(term_pin[0], 5) && $past(term_pin[0], 1500))
        else $error("terminal accepted before settling");
endmodule
bind dtc_decoder dtc_decoder_sva #(.N_TERM(N_TERM)) u_dtc_decoder_sva (
    .core_clk(core_clk), .rst_n(rst_n), .term_pin(term_pin),
    .motor_running(motor_running), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd(cmd), .bias_en(bias_en), .bias_level(bias_level),
    .freq_restore(freq_restore), .user_logic_terms(user_logic_terms));
`default_nettype wire

// ### bench/dtc_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_decoder_tb;
    import dtc_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        run_r    = 1'b0;
    logic        brk_r    = 1'b0;
    logic        coast_r  = 1'b0;
    logic [15:0] freq_r   = 16'h0;
    logic [15:0] abias_r  = 16'h0123;
    logic [7:0]  addr_r   = 8'h0;
    logic [31:0] wdata_r  = 32'h0;
    logic        wr_r     = 1'b0;
    logic        rd_r     = 1'b0;
    logic [7:0]  want     = 8'h0;
    logic [31:0] rdata, v;
    logic [7:0]  pin, ul_terms;
    dtc_cmd_type cmd, idle_c;
    logic        bias_en, restore;
    logic [15:0] bias_level, bias_value, restore_val;
    int          fail_count = 0;
    int          total_checks = 0;
    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;
    dtc_switch_model u_dtc_switch_model (.core_clk(core_clk), .want(want),
        .term_pin(pin));
    dtc_decoder #(.SEC_CYC(50)) u_dtc_decoder (
        .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .term_pin(pin),
        .motor_running(run_r), .brake_command(brk_r), .coast_stop(coast_r),
        .freq_cmd_in(freq_r), .analog_bias(abias_r), .reg_addr(addr_r),
        .reg_wdata(wdata_r), .reg_wr(wr_r), .reg_rd(rd_r),
        .reg_rdata(rdata), .cmd(cmd), .bias_en(bias_en),
        .bias_level(bias_level), .bias_value(bias_value),
        .freq_restore(restore), .freq_restore_val(restore_val),
        .user_logic_terms(ul_terms));
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic settle;
        cyc(3);
        @(negedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, exp, input string nm);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr_r  <= a;
        wdata_r <= d;
        wr_r    <= 1'b1;
        @(posedge core_clk);
        wr_r    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
        @(posedge core_clk);
        addr_r <= a;
        rd_r   <= 1'b1;
        @(posedge core_clk);
        rd_r   <= 1'b0;
        @(negedge core_clk);
        v = rdata;
        if (nm != "") chk(v, e, nm);
    endtask
    task automatic fn(input int s, input logic [7:0] c);
        wr(A_TERM_FUNC + 8'(s), {24'h0, c});
    endtask
    // Move the switches and wait out the debounce
    task automatic pins(input logic [7:0] p);
        @(posedge core_clk);
        want <= p;
        cyc(DEB_CYC + 20);
        @(negedge core_clk);
    endtask
    task automatic t_reset;
        settle();
        chk(cmd, idle_c, "cmd after reset");
        rd(A_BRAKE_TIME, {16'h0, BRAKE_TIME_RST}, "brake time");
        rd(A_TERM_FUNC, {24'h0, FN_NONE}, "slot code");
        rd(8'h20, 32'h0, "unmapped");
        $display("reset test done");
    endtask
    task automatic t_select;
        logic [7:0] c [8] = '{FN_RUN_FWD, FN_RUN_BWD, FN_BIAS_LOW,
            FN_BIAS_HIGH, FN_SPD_LOW, FN_SPD_HIGH, FN_LOOP_LOW, FN_LOOP_HIGH};
        logic [1:0] b;
        for (int i = 0; i < 8; i++) fn(i, c[i]);
        for (int i = 0; i < 3; i++) wr(A_BIAS_ONE + 8'(i), 32'h11 * (i + 1));
        for (int k = 0; k < 4; k++) begin
            b = 2'(k);
            pins({b, b, b, 2'b00});
            chk(ul_terms, {b, b, b, 2'b00}, "terminals");
            chk(bias_en, b != 2'b00, "bias enable");
            chk(bias_level, 16'h11 * b, "bias level");
            chk(cmd.speed_param_idx, b, "speed set");
            chk(cmd.loop_step_idx, b, "loop step");
        end
        $display("select test done");
    endtask
    task automatic t_hold;
        @(posedge core_clk) run_r <= 1'b1;
        pins(8'hf0);
        chk(bias_level, 16'h33, "held level");
        @(posedge core_clk) run_r <= 1'b0;
        settle();
        chk(bias_level, 16'h0, "released level");
        $display("hold test done");
    endtask
    task automatic t_levels;
        logic [7:0] c [4] = '{FN_DROOP, FN_UL_CANCEL, FN_UL_TCLR, FN_REGEN_CCL};
        for (int i = 0; i < 4; i++) fn(4 + i, c[i]);
        settle();
        chk(cmd.droop_en, 1, "droop");
        chk(cmd.user_logic_run, 0, "user logic run");
        chk(cmd.user_logic_tclr, 1, "timer clear");
        chk(cmd.regen_avoid_en, 0, "regen avoid");
        fn(4, FN_LSC_CANCEL);
        fn(5, FN_BIAS_HOLD);
        @(posedge core_clk) abias_r <= 16'h0abc;
        settle();
        chk(cmd.pi_comp_en, 0, "pi comp");
        chk(bias_value, 16'h0123, "frozen bias");
        fn(5, FN_NONE);
        fn(4, FN_NONE);
        wr(A_CTRL, 32'h0);
        settle();
        chk(bias_value, 16'h0abc, "live bias");
        chk(cmd.pi_comp_en, 0, "pi comp config");
        wr(A_CTRL, 32'h1);
        fn(6, FN_NONE);
        fn(7, FN_NONE);
        settle();
        chk(cmd, idle_c, "none slots");
        $display("level test done");
    endtask
    task automatic t_run;
        fn(4, FN_RUN_FWD);
        settle();
        chk(cmd, idle_c, "run code off slot");
        pins(8'hf1);
        chk(cmd.run_forward, 1, "forward");
        pins(8'hf2);
        chk(cmd.run_backward, 1, "backward");
        chk(cmd.run_forward, 0, "forward off");
        pins(8'hf0);
        chk(cmd.decel_stop, 1, "stop");
        $display("run test done");
    endtask
    task automatic t_brake;
        fn(4, FN_BRAKE_FB);
        wr(A_BRAKE_TIME, 32'h2);
        @(posedge core_clk) brk_r <= 1'b1;
        run_r <= 1'b1;
        cyc(600);
        @(negedge core_clk);
        chk(cmd.alarm_stop, 0, "brake agree");
        @(posedge core_clk) brk_r <= 1'b0;
        cyc(150);
        @(negedge core_clk);
        chk(cmd.alarm_stop, 0, "brake grace");
        cyc(450);
        @(negedge core_clk);
        chk(cmd.alarm_stop, 1, "brake trip");
        rd(A_STATUS, 32'h5, "fault status");
        @(posedge core_clk) brk_r <= 1'b1;
        run_r <= 1'b0;
        wr(A_CTRL, 32'h3);
        settle();
        chk(cmd.alarm_stop, 0, "fault cleared");
        $display("brake test done");
    endtask
    task automatic t_save;
        logic seen;
        fn(5, FN_LSC_SAVE);
        @(posedge core_clk) freq_r <= 16'h1234;
        run_r <= 1'b1;
        cyc(5);
        @(posedge core_clk) run_r <= 1'b0;
        cyc(3);
        @(posedge core_clk) freq_r <= 16'h0;
        fn(5, FN_NONE);
        rd(A_SAVED_FREQ, 32'h1234, "saved freq");
        rd(A_STATUS, 32'h2, "saved status");
        @(posedge core_clk) run_r <= 1'b1;
        seen = 1'b0;
        repeat (5) @(negedge core_clk) seen |= restore;
        chk(seen, 1, "restore pulse");
        chk(restore_val, 16'h1234, "restore value");
        fn(5, FN_LSC_SAVE);
        @(posedge core_clk) freq_r <= 16'h0777;
        coast_r <= 1'b1;
        @(posedge core_clk) coast_r <= 1'b0;
        fn(5, FN_NONE);
        rd(A_SAVED_FREQ, 32'h777, "coast save");
        @(posedge core_clk) run_r <= 1'b0;
        $display("save test done");
    endtask
    task automatic t_mains;
        fn(6, FN_MAINS_ONE);
        cyc(250);
        fn(7, FN_MAINS_TWO);
        cyc(250);
        fn(6, FN_NONE);
        fn(7, FN_NONE);
        rd(A_MAINS_ONE, 32'h0, "");
        chk(v >= 9 && v <= 11, 1, "mains one seconds");
        rd(A_MAINS_TWO, 32'h0, "");
        chk(v >= 4 && v <= 6, 1, "mains two seconds");
        $display("mains test done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        idle_c = '0;
        idle_c.decel_stop = 1'b1;
        idle_c.user_logic_run = 1'b1;
        idle_c.regen_avoid_en = 1'b1;
        idle_c.pi_comp_en = 1'b1;
        cyc(10);
        rst_n <= 1'b1;
        t_reset();
        t_select();
        t_hold();
        t_levels();
        t_run();
        t_brake();
        t_save();
        t_mains();
        give_verdict();
    end
    // Watchdog
    initial begin
        cyc(60000);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire

// ### bench/dtc_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_switch_model #(
    parameter int unsigned N_TERM = 8
) (
    input  wire logic              core_clk,
    input  wire logic [N_TERM-1:0] want,
    output logic      [N_TERM-1:0] term_pin
);
    logic [N_TERM-1:0] last_r = '0;
    logic [N_TERM-1:0] chg_r  = '0;
    logic [3:0]        cnt_r  = 4'h0;
    // Contacts chatter for a few cycles after each change, then settle
    always @(posedge core_clk) begin
        if (want != last_r) begin
            chg_r <= want ^ last_r;
            cnt_r <= 4'h9;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
        last_r   <= want;
        term_pin <= want ^ (cnt_r[0] ? chg_r : '0);
    end
endmodule
`default_nettype wire

// ### hdl/dtc_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_decoder
    import dtc_pkg::*;
#(
    parameter int unsigned N_TERM    = 8,
    parameter int unsigned RUN_SLOTS = 2,
    parameter int unsigned SEC_CYC   = SEC_NS / CLK_PERIOD_NS
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic [N_TERM-1:0] term_pin,
    input  wire logic          motor_running,
    input  wire logic          brake_command,
    input  wire logic          coast_stop,
    input  wire logic [15:0]   freq_cmd_in,
    input  wire logic [15:0]   analog_bias,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [31:0]        reg_rdata,
    output dtc_cmd_type        cmd,
    output logic               bias_en,
    output logic [15:0]        bias_level,
    output logic [15:0]        bias_value,
    output logic               freq_restore,
    output logic [15:0]        freq_restore_val,
    output logic [N_TERM-1:0]  user_logic_terms
);

    localparam int unsigned DW = $clog2(DEB_CYC + 1);
    localparam int unsigned UW = $clog2(US_CYC + 1);

    logic [N_TERM-1:0] term_meta_r;
    logic [N_TERM-1:0] term_sync_r;
    logic [N_TERM-1:0] term_deb;
    logic [7:0]        func_r [N_TERM];
    logic [15:0]       bias_lvl_r [3];
    logic [15:0]       brake_time_r;
    logic              lsc_en_r;
    logic [1:0]        bias_sel_r;
    logic [15:0]       bias_value_r;
    logic [UW-1:0]     us_cnt_r;
    logic              us_tick;
    logic [15:0]       mis_cnt_r;
    logic              mismatch;
    logic              fault_set;
    logic              fault_r;
    logic              run_prev_r;
    logic              cancel_prev_r;
    logic              save_ev;
    logic [15:0]       saved_freq_r;
    logic              saved_valid_r;
    logic              restore_r;
    logic [15:0]       restore_val_r;
    logic [31:0]       sec_cnt_r;
    logic              sec_tick;
    logic [31:0]       mains_one_r;
    logic [31:0]       mains_two_r;
    logic [31:0]       rdata_r;
    logic [31:0]       rdata_nxt;
    dtc_cmd_type       cmd_r;
    dtc_cmd_type       cmd_nxt;
    dtc_term_type      t;
    logic              wr_ctrl;

    // Two-stage synchroniser on the terminal pins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            term_meta_r <= '0;
            term_sync_r <= '0;
        end else if (ce) begin
            term_meta_r <= term_pin;
            term_sync_r <= term_meta_r;
        end
    end

    // Per-terminal debounce: accept a level stable for DEB_CYC cycles
    genvar g;
    generate
        for (g = 0; g < N_TERM; g++) begin : g_deb
            logic [DW-1:0] cnt_r;
            logic          deb_r;
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_r <= '0;
                    deb_r <= 1'b0;
                end else if (ce) begin
                    if (term_sync_r[g] == deb_r) begin
                        cnt_r <= '0;
                    end else if (cnt_r == DW'(DEB_CYC - 1)) begin
                        cnt_r <= '0;
                        deb_r <= term_sync_r[g];
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            end
            assign term_deb[g] = deb_r;
        end
    endgenerate

    // Gather each function from every terminal assigned to it; run codes count only on the first RUN_SLOTS terminals
    always_comb begin
        t = '0;
        for (int i = 0; i < N_TERM; i++) begin
            if (term_deb[i]) begin
                case (func_r[i])
                    FN_BIAS_LOW:   t.bias_select_low = 1'b1;
                    FN_BIAS_HIGH:  t.bias_select_high = 1'b1;
                    FN_BIAS_HOLD:  t.bias_hold = 1'b1;
                    FN_BRAKE_FB:   t.brake_feedback = 1'b1;
                    FN_LSC_CANCEL: t.line_speed_cancel = 1'b1;
                    FN_LSC_SAVE:   t.line_speed_save = 1'b1;
                    FN_MAINS_ONE:  t.mains_run_motor_one = 1'b1;
                    FN_MAINS_TWO:  t.mains_run_motor_two = 1'b1;
                    FN_DROOP:      t.droop = 1'b1;
                    FN_SPD_LOW:    t.speed_param_sel_low = 1'b1;
                    FN_SPD_HIGH:   t.speed_param_sel_high = 1'b1;
                    FN_UL_CANCEL:  t.user_logic_cancel = 1'b1;
                    FN_UL_TCLR:    t.user_logic_timer_clear = 1'b1;
                    FN_REGEN_CCL:  t.regen_avoid_cancel = 1'b1;
                    FN_LOOP_LOW:   t.loop_step_sel_low = 1'b1;
                    FN_LOOP_HIGH:  t.loop_step_sel_high = 1'b1;
                    // Run commands only on dedicated slots
                    FN_RUN_FWD:    t.run_forward |= (i < RUN_SLOTS);
                    FN_RUN_BWD:    t.run_backward |= (i < RUN_SLOTS);
                    default:       ;
                endcase
            end
        end
    end

    // Command word towards the control core
    always_comb begin
        cmd_nxt = '0;
        cmd_nxt.run_forward  = t.run_forward & ~t.run_backward;
        cmd_nxt.run_backward = t.run_backward & ~t.run_forward;
        cmd_nxt.decel_stop   = ~(t.run_forward ^ t.run_backward);
        cmd_nxt.droop_en     = t.droop;
        cmd_nxt.speed_param_idx = {t.speed_param_sel_high,
                                   t.speed_param_sel_low};
        cmd_nxt.loop_step_idx   = {t.loop_step_sel_high,
                                   t.loop_step_sel_low};
        cmd_nxt.user_logic_run  = ~t.user_logic_cancel;
        cmd_nxt.user_logic_tclr = t.user_logic_timer_clear;
        cmd_nxt.regen_avoid_en  = ~t.regen_avoid_cancel;
        cmd_nxt.pi_comp_en = lsc_en_r & ~t.line_speed_cancel;
        cmd_nxt.alarm_stop = fault_r;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= '0;
        end else if (ce) begin
            cmd_r <= cmd_nxt;
        end
    end

    // Bias select latched only while the motor is stopped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bias_sel_r <= 2'h0;
        end else if (ce && !motor_running) begin
            bias_sel_r <= {t.bias_select_high, t.bias_select_low};
        end
    end

    // Analog bias held while the hold terminal is on
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bias_value_r <= 16'h0000;
        end else if (ce && !t.bias_hold) begin
            bias_value_r <= analog_bias;
        end
    end

    // Microsecond prescaler for brake timing
    assign us_tick = (us_cnt_r == UW'(US_CYC - 1));
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            us_cnt_r <= '0;
        end else if (ce) begin
            us_cnt_r <= us_tick ? '0 : us_cnt_r + 1'b1;
        end
    end

    // Brake check: mismatch must outlast the response time
    assign mismatch  = motor_running & (brake_command != t.brake_feedback);
    assign fault_set = mismatch & (mis_cnt_r >= brake_time_r);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mis_cnt_r <= 16'h0000;
        end else if (ce) begin
            if (!mismatch) begin
                mis_cnt_r <= 16'h0000;
            end else if (us_tick && mis_cnt_r != 16'hffff) begin
                mis_cnt_r <= mis_cnt_r + 16'h0001;
            end
        end
    end

    // Sticky fault; a new mismatch wins over a clear
    assign wr_ctrl = reg_wr && reg_addr == A_CTRL;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_r <= 1'b0;
        end else if (ce) begin
            if (fault_set) begin
                fault_r <= 1'b1;
            end else if (wr_ctrl && reg_wdata[CTRL_FAULT_CLR]) begin
                fault_r <= 1'b0;
            end
        end
    end

    // Edge history for run and cancel
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_prev_r    <= 1'b0;
            cancel_prev_r <= 1'b0;
        end else if (ce) begin
            run_prev_r    <= motor_running;
            cancel_prev_r <= t.line_speed_cancel;
        end
    end

    // Save compensated frequency on any kind of stop or cancel release
    assign save_ev = t.line_speed_save &
                     ((run_prev_r & ~motor_running) | fault_set |
                      coast_stop |
                      (cancel_prev_r & ~t.line_speed_cancel));
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            saved_freq_r  <= 16'h0000;
            saved_valid_r <= 1'b0;
        end else if (ce) begin
            if (save_ev) begin
                saved_freq_r  <= freq_cmd_in;
                saved_valid_r <= 1'b1;
            end else if (wr_ctrl && reg_wdata[CTRL_SAVE_CLR]) begin
                saved_valid_r <= 1'b0;
            end
        end
    end

    // Restore pulse on restart when a saved value exists
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            restore_r     <= 1'b0;
            restore_val_r <= 16'h0000;
        end else if (ce) begin
            restore_r <= motor_running & ~run_prev_r & saved_valid_r;
            if (motor_running && !run_prev_r) begin
                restore_val_r <= saved_freq_r;
            end
        end
    end

    // One-second tick for run time counting
    assign sec_tick = (sec_cnt_r == 32'(SEC_CYC - 1));
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_r <= 32'h00000000;
        end else if (ce) begin
            sec_cnt_r <= sec_tick ? 32'h00000000 : sec_cnt_r + 32'h00000001;
        end
    end

    // Mains run time per motor, in seconds
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mains_one_r <= 32'h00000000;
            mains_two_r <= 32'h00000000;
        end else if (ce && sec_tick) begin
            if (t.mains_run_motor_one) begin
                mains_one_r <= mains_one_r + 32'h00000001;
            end
            if (t.mains_run_motor_two) begin
                mains_two_r <= mains_two_r + 32'h00000001;
            end
        end
    end

    // Software writes to configuration
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_TERM; i++) begin
                func_r[i] <= FN_NONE;
            end
            for (int k = 0; k < 3; k++) begin
                bias_lvl_r[k] <= 16'h0000;
            end
            brake_time_r <= BRAKE_TIME_RST;
            lsc_en_r     <= LSC_EN_RST;
        end else if (ce && reg_wr) begin
            for (int i = 0; i < N_TERM; i++) begin
                if (reg_addr == A_TERM_FUNC + 8'(i)) begin
                    func_r[i] <= reg_wdata[7:0];
                end
            end
            case (reg_addr)
                A_BIAS_ONE:   bias_lvl_r[0] <= reg_wdata[15:0];
                A_BIAS_TWO:   bias_lvl_r[1] <= reg_wdata[15:0];
                A_BIAS_THREE: bias_lvl_r[2] <= reg_wdata[15:0];
                A_BRAKE_TIME: brake_time_r <= reg_wdata[15:0];
                A_CTRL:       lsc_en_r <= reg_wdata[CTRL_LSC_EN];
                default:      ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        for (int i = 0; i < N_TERM; i++) begin
            if (reg_addr == A_TERM_FUNC + 8'(i)) begin
                rdata_nxt = {24'h000000, func_r[i]};
            end
        end
        case (reg_addr)
            A_BIAS_ONE:   rdata_nxt = {16'h0000, bias_lvl_r[0]};
            A_BIAS_TWO:   rdata_nxt = {16'h0000, bias_lvl_r[1]};
            A_BIAS_THREE: rdata_nxt = {16'h0000, bias_lvl_r[2]};
            A_BRAKE_TIME: rdata_nxt = {16'h0000, brake_time_r};
            A_CTRL:       rdata_nxt[CTRL_LSC_EN] = lsc_en_r;
            A_STATUS: begin
                rdata_nxt[ST_FAULT]   = fault_r;
                rdata_nxt[ST_SAVED]   = saved_valid_r;
                rdata_nxt[ST_RUNNING] = motor_running;
            end
            A_TERMS:      rdata_nxt[N_TERM-1:0] = term_deb;
            A_MAINS_ONE:  rdata_nxt = mains_one_r;
            A_MAINS_TWO:  rdata_nxt = mains_two_r;
            A_SAVED_FREQ: rdata_nxt = {16'h0000, saved_freq_r};
            default:      ;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h00000000;
        end else if (ce) begin
            rdata_r <= reg_rd ? rdata_nxt : 32'h00000000;
        end
    end

    // Outputs
    assign reg_rdata        = rdata_r;
    assign cmd              = cmd_r;
    assign bias_en          = bias_sel_r != 2'h0;
    assign bias_level       = bias_en ? bias_lvl_r[bias_sel_r - 2'h1]
                                      : 16'h0000;
    assign bias_value       = bias_value_r;
    assign freq_restore     = restore_r;
    assign freq_restore_val = restore_val_r;
    assign user_logic_terms = term_deb;

endmodule
`default_nettype wire

// ### hdl/dtc_pkg.sv
package dtc_pkg;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned DEB_TIME_NS   = 10000;
    localparam int unsigned DEB_CYC       =
        (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned US_NS         = 1000;
    localparam int unsigned US_CYC        = US_NS / CLK_PERIOD_NS;
    localparam int unsigned SEC_NS        = 1000000000;
    // Terminal function codes
    localparam logic [7:0] FN_BIAS_LOW   = 8'h3d;
    localparam logic [7:0] FN_BIAS_HIGH  = 8'h3e;
    localparam logic [7:0] FN_BIAS_HOLD  = 8'h3f;
    localparam logic [7:0] FN_BRAKE_FB   = 8'h41;
    localparam logic [7:0] FN_LSC_CANCEL = 8'h46;
    localparam logic [7:0] FN_LSC_SAVE   = 8'h47;
    localparam logic [7:0] FN_MAINS_ONE  = 8'h48;
    localparam logic [7:0] FN_MAINS_TWO  = 8'h49;
    localparam logic [7:0] FN_DROOP      = 8'h4c;
    localparam logic [7:0] FN_SPD_LOW    = 8'h4e;
    localparam logic [7:0] FN_SPD_HIGH   = 8'h4f;
    localparam logic [7:0] FN_UL_CANCEL  = 8'h50;
    localparam logic [7:0] FN_UL_TCLR    = 8'h51;
    localparam logic [7:0] FN_REGEN_CCL  = 8'h52;
    localparam logic [7:0] FN_RUN_FWD    = 8'h62;
    localparam logic [7:0] FN_RUN_BWD    = 8'h63;
    localparam logic [7:0] FN_NONE       = 8'h64;
    localparam logic [7:0] FN_LOOP_LOW   = 8'hab;
    localparam logic [7:0] FN_LOOP_HIGH  = 8'hac;
    // Register addresses
    localparam logic [7:0] A_TERM_FUNC   = 8'h00;
    localparam logic [7:0] A_BIAS_ONE    = 8'h10;
    localparam logic [7:0] A_BIAS_TWO    = 8'h11;
    localparam logic [7:0] A_BIAS_THREE  = 8'h12;
    localparam logic [7:0] A_BRAKE_TIME  = 8'h13;
    localparam logic [7:0] A_CTRL        = 8'h14;
    localparam logic [7:0] A_STATUS      = 8'h15;
    localparam logic [7:0] A_TERMS       = 8'h16;
    localparam logic [7:0] A_MAINS_ONE   = 8'h17;
    localparam logic [7:0] A_MAINS_TWO   = 8'h18;
    localparam logic [7:0] A_SAVED_FREQ  = 8'h19;
    // Field positions
    localparam int unsigned CTRL_LSC_EN    = 0;
    localparam int unsigned CTRL_FAULT_CLR = 1;
    localparam int unsigned CTRL_SAVE_CLR  = 2;
    localparam int unsigned ST_FAULT       = 0;
    localparam int unsigned ST_SAVED       = 1;
    localparam int unsigned ST_RUNNING     = 2;
    // Reset values
    localparam logic [15:0] BRAKE_TIME_RST = 16'h0064;
    localparam logic        LSC_EN_RST     = 1'b1;

    // Decoded terminal levels
    typedef struct packed {
        logic bias_select_low;
        logic bias_select_high;
        logic bias_hold;
        logic brake_feedback;
        logic line_speed_cancel;
        logic line_speed_save;
        logic mains_run_motor_one;
        logic mains_run_motor_two;
        logic droop;
        logic speed_param_sel_low;
        logic speed_param_sel_high;
        logic user_logic_cancel;
        logic user_logic_timer_clear;
        logic regen_avoid_cancel;
        logic loop_step_sel_low;
        logic loop_step_sel_high;
        logic run_forward;
        logic run_backward;
    } dtc_term_type;

    // Commands to the control core
    typedef struct packed {
        logic       run_forward;
        logic       run_backward;
        logic       decel_stop;
        logic       droop_en;
        logic [1:0] speed_param_idx;
        logic [1:0] loop_step_idx;
        logic       user_logic_run;
        logic       user_logic_tclr;
        logic       regen_avoid_en;
        logic       pi_comp_en;
        logic       alarm_stop;
    } dtc_cmd_type;
endpackage
